/* File: inc/rgbs_pkg.sv */
// Purpose: shared constants and types of the colour sensor readout block
// Assumes: 100 MHz system clock
// Notes:   register pointers, control field positions, reset values, timing
package rgbs_pkg;
  localparam logic [6:0] DEV_ADDR      = 7'h2a;
  localparam logic [7:0] PTR_CTRL      = 8'h00;
  localparam logic [7:0] PTR_TMAN_HI   = 8'h01;
  localparam logic [7:0] PTR_TMAN_LO   = 8'h02;
  localparam logic [7:0] PTR_RES_FIRST = 8'h03;
  localparam logic [7:0] PTR_RES_LAST  = 8'h0a;
  // control byte fields
  localparam int CTRL_ADC_RST = 7;
  localparam int CTRL_STBY    = 6;
  localparam int CTRL_MON     = 5;
  localparam int CTRL_GAIN    = 3;
  localparam int CTRL_MANUAL  = 2;
  localparam logic [7:0]  CTRL_WR_MASK = 8'hcf;  // monitor and bit 4 are not writable
  localparam logic [7:0]  CTRL_RST_VAL = 8'he4;
  localparam logic [15:0] TMAN_RST_VAL = 16'h0c30;
  // timing: base step of the integration clock
  localparam real CLK_MHZ       = 100.0;
  localparam real BASE_STEP_US  = 87.5;
  localparam int  BASE_STEP_CYC = int'(BASE_STEP_US * CLK_MHZ);
  // log2 of base steps per channel for step select 00..11; manual mode multiplies the count by twice the timing value
  localparam int  STEP_SHIFT [4] = '{0, 4, 8, 11};
  localparam int  CHAN_COUNT     = 4;
  typedef logic [3:0][15:0] rgbs_chan_set_t;  // [0] red .. [3] unfiltered reference
endpackage

/* File: inc/rgbs_meas_if.sv */
// Purpose: carries settings and results between bus port and sequencer
// Assumes: both ends on mclk_i
// Notes:   ctl end owns the settings, meas end owns the results
`timescale 1ns/1ns
interface rgbs_meas_if;
  logic [7:0]               ctrl;
  logic [15:0]              tman;
  rgbs_pkg::rgbs_chan_set_t result;
  logic                     standby_mon;
  modport ctl  (output ctrl, tman, input  result, standby_mon);
  modport meas (input  ctrl, tman, output result, standby_mon);
endinterface

/* File: design/rgbs_integrator.sv */
// Purpose: measurement sequencer, integrates four channels in turn
// Assumes: channel samples arrive on mclk_i; BASE_CYC clocks per base step
// Notes:   results change only when a whole set is done
`timescale 1ns/1ns
module rgbs_integrator #(
  parameter int BASE_CYC = rgbs_pkg::BASE_STEP_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire rgbs_pkg::rgbs_chan_set_t chan_sample_i,
  rgbs_meas_if.meas                     mif
);
  typedef struct packed {
    logic [15:0]              base_cnt;
    logic [31:0]              step_cnt;
    logic [1:0]               chan;
    logic                     mon;
    rgbs_pkg::rgbs_chan_set_t shadow;
    rgbs_pkg::rgbs_chan_set_t result;
  } rgbs_int_state_t;

  rgbs_int_state_t          r, n;
  logic                     run, manual, tick, step_end, set_end;
  logic [31:0]              limit;
  rgbs_pkg::rgbs_chan_set_t tmp;

  // steps per channel and run condition
  always_comb begin
    manual = mif.ctrl[rgbs_pkg::CTRL_MANUAL];
    limit  = manual ? ({16'h0, mif.tman} << (rgbs_pkg::STEP_SHIFT[mif.ctrl[1:0]] + 1))
                    : (32'h1 << rgbs_pkg::STEP_SHIFT[mif.ctrl[1:0]]);  // [R5] [R7]
    if (limit == 32'h0) begin
      limit = 32'h1;  // zero multiple runs one step
    end
    run      = !mif.ctrl[rgbs_pkg::CTRL_ADC_RST] && !mif.ctrl[rgbs_pkg::CTRL_STBY] && !r.mon;
    tick     = run && (r.base_cnt == 16'(BASE_CYC - 1));
    step_end = tick && (r.step_cnt == limit - 32'h1);
    set_end  = step_end && (r.chan == 2'(rgbs_pkg::CHAN_COUNT - 1));
  end

  // sequencer next state
  always_comb begin
    n   = r;
    tmp = r.shadow;
    if (!run) begin
      n.base_cnt = '0;
      n.step_cnt = '0;
      n.chan     = '0;
      if (mif.ctrl[rgbs_pkg::CTRL_ADC_RST]) begin
        n.mon = 1'b0;  // releasing reset later starts a fresh set [R4]
      end
    end else begin
      n.base_cnt = tick ? 16'h0 : r.base_cnt + 16'h1;
      if (step_end) begin
        tmp[r.chan] = chan_sample_i[r.chan];
        n.shadow    = tmp;
        n.step_cnt  = '0;
        n.chan      = r.chan + 2'd1;
        if (set_end) begin
          n.result = tmp;     // whole coherent set at once [R15]
          n.mon    = manual;  // manual stops, fixed period repeats [R8] [R14]
        end
      end else if (tick) begin
        n.step_cnt = r.step_cnt + 32'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r     <= '0;
      r.mon <= rgbs_pkg::CTRL_RST_VAL[rgbs_pkg::CTRL_MON];
    end else begin
      r <= n;
    end
  end

  assign mif.result      = r.result;
  assign mif.standby_mon = r.mon;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_chan_advance: assert property (step_end |=> r.chan == $past(r.chan) + 2'd1) // [R5]
    else $error("channel did not advance at end of its steps");
  a_manual_stop: assert property (set_end && manual |=> r.mon && !run) // [R14]
    else $error("manual mode did not enter standby after a set");
  a_fixed_repeat: assert property (set_end && !manual |=> !r.mon ##1 run) // [R8]
    else $error("fixed period mode stopped after a set");
  a_result_hold: assert property (!set_end |=> $stable(r.result)) // [R15]
    else $error("results changed outside a set end");
  a_reset_idle: assert property (mif.ctrl[rgbs_pkg::CTRL_ADC_RST] |=> r.chan == 2'd0 && !r.mon) // [R4]
    else $error("converter reset did not clear the sequence");
  c_manual_set: cover property (set_end && manual);
  c_fixed_two: cover property (set_end && !manual ##[1:1000] set_end);
endmodule // rgbs_integrator

/* File: design/rgbs_i2c_readout.sv */
// Purpose: I2C target port of a four channel colour sensor
// Assumes: scl/sda pins asynchronous to mclk_i, sampled through two flops
// Notes:   open drain sda: oe high pulls the line low, sda_o is always 0
`timescale 1ns/1ns
// Notes on behaviour
// R1: answer at seven bit address 0x2A; direction bit 0 write, 1 read.
// R2: first written byte sets pointer; later bytes land at pointer, 0x00 is control.
// R3: host writes 0x84 first, holding the converter in reset, standby off.
// R4: writing 0x04 releases converter reset and starts integration.
// R5: manual step 00 integrates 175 us times the 16-bit timing value per channel.
// R6: host waits longer than all four channel integrations before reading.
// R7: 0x89 then 0x09 gives fixed period, high gain, 1.4 ms per channel.
// R8: fixed period mode repeats measurements on its own without commands.
// R9: host writes pointer 0x03, then repeated start and read address.
// R10: read returns eight bytes, pointer auto advances, red green blue reference, high first.
// R11: host acks every byte except the last, then nacks and stops.
// R12: device acks its address, every pointer byte and every control byte.
// R13: control bits: reset, standby, monitor, gain, manual, two step select bits.
// R14: manual mode auto standby after one set; fixed period repeats continuously.
// R15: result bytes update only at the end of a full set.
module rgbs_i2c_readout #(
  parameter int BASE_CYC = rgbs_pkg::BASE_STEP_CYC
) (
  input  wire logic                     mclk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output wire logic                     sda_o,
  output wire logic                     sda_oe_o,
  input  wire rgbs_pkg::rgbs_chan_set_t chan_sample_i,
  output wire logic                     standby_mon_o
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_AACK, S_WBYTE, S_WACK, S_RBYTE, S_RACK
  } rgbs_st_t;

  typedef struct packed {
    logic        scl_s1, scl_s2, scl_p;
    logic        sda_s1, sda_s2, sda_p;
    rgbs_st_t    st;
    logic [2:0]  bitc;
    logic [1:0]  ph;
    logic [7:0]  sh;
    logic        rw;
    logic        first;
    logic        drive;
    logic [7:0]  ptr;
    logic [7:0]  ctrl;
    logic [15:0] tman;
  } rgbs_port_state_t;

  rgbs_port_state_t r, n;
  logic [1:0]       rst_sync_r;
  logic             rst_n;
  logic             scl_rise, scl_fall, start_c, stop_c;
  logic [7:0]       new_byte, rd_byte;
  rgbs_meas_if      mif ();

  // register byte seen by a read at pointer p
  function automatic logic [7:0] reg_byte(input logic [7:0] p, input logic [7:0] c,
                                          input logic m, input logic [15:0] t,
                                          input rgbs_pkg::rgbs_chan_set_t res);
    logic [7:0] off;
    off = p - rgbs_pkg::PTR_RES_FIRST;
    if (p == rgbs_pkg::PTR_CTRL) begin
      return {c[7:6], m, 1'b0, c[3:0]};  // monitor bit is read only [R13]
    end else if (p == rgbs_pkg::PTR_TMAN_HI) begin
      return t[15:8];
    end else if (p == rgbs_pkg::PTR_TMAN_LO) begin
      return t[7:0];
    end else if (p >= rgbs_pkg::PTR_RES_FIRST && p <= rgbs_pkg::PTR_RES_LAST) begin
      return off[0] ? res[off[2:1]][7:0] : res[off[2:1]][15:8];  // high byte first [R10]
    end
    return 8'h00;
  endfunction

  // reset release through two flops
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // bus events from synchronised pins
  always_comb begin
    scl_rise = r.scl_s2 && !r.scl_p;
    scl_fall = !r.scl_s2 && r.scl_p;
    start_c  = r.scl_s2 && r.scl_p && r.sda_p && !r.sda_s2;
    stop_c   = r.scl_s2 && r.scl_p && !r.sda_p && r.sda_s2;
    new_byte = {r.sh[6:0], r.sda_s2};
    rd_byte  = reg_byte(r.ptr, r.ctrl, mif.standby_mon, r.tman, mif.result);
  end

  // target protocol engine
  always_comb begin
    n        = r;
    n.scl_s1 = scl_i;
    n.scl_s2 = r.scl_s1;
    n.scl_p  = r.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = r.sda_s1;
    n.sda_p  = r.sda_s2;
    if (start_c) begin
      n.st    = S_ADDR;  // start and repeated start alike
      n.bitc  = 3'd0;
      n.drive = 1'b0;
    end else if (stop_c) begin
      n.st    = S_IDLE;
      n.drive = 1'b0;
    end else begin
      unique case (r.st)
        S_IDLE: begin
        end
        S_ADDR, S_WBYTE: begin
          if (scl_rise) begin
            n.sh   = new_byte;
            n.bitc = r.bitc + 3'd1;
            if (r.bitc == 3'd7) begin
              n.ph = 2'd0;
              if (r.st == S_ADDR) begin
                if (new_byte[7:1] == rgbs_pkg::DEV_ADDR) begin  // [R1]
                  n.st    = S_AACK;
                  n.rw    = new_byte[0];
                  n.first = 1'b1;
                end else begin
                  n.st = S_IDLE;  // other target, stay off the bus
                end
              end else begin
                n.st = S_WACK;
                if (r.first) begin
                  n.ptr   = new_byte;  // pointer byte [R2]
                  n.first = 1'b0;
                end else begin
                  if (r.ptr == rgbs_pkg::PTR_CTRL) begin
                    n.ctrl = new_byte & rgbs_pkg::CTRL_WR_MASK;  // [R2] [R4] [R7] [R13]
                  end else if (r.ptr == rgbs_pkg::PTR_TMAN_HI) begin
                    n.tman[15:8] = new_byte;
                  end else if (r.ptr == rgbs_pkg::PTR_TMAN_LO) begin
                    n.tman[7:0] = new_byte;
                  end
                  n.ptr = r.ptr + 8'd1;
                end
              end
            end
          end
        end
        S_AACK, S_WACK: begin
          if (scl_fall) begin
            if (r.ph == 2'd0) begin
              n.drive = 1'b1;  // pull low for the ack bit [R12]
              n.ph    = 2'd1;
            end else begin
              n.ph   = 2'd0;
              n.bitc = 3'd0;
              if (r.st == S_AACK && r.rw) begin
                n.st    = S_RBYTE;
                n.sh    = rd_byte;
                n.drive = !rd_byte[7];
              end else begin
                n.st    = S_WBYTE;
                n.drive = 1'b0;
              end
            end
          end
        end
        S_RBYTE: begin
          if (scl_rise) begin
            n.bitc = r.bitc + 3'd1;
            if (r.bitc == 3'd7) begin
              n.st  = S_RACK;
              n.ph  = 2'd0;
              n.ptr = r.ptr + 8'd1;  // auto advance after each byte [R10]
            end
          end else if (scl_fall) begin
            n.sh    = {r.sh[6:0], 1'b0};
            n.drive = !r.sh[6];
          end
        end
        S_RACK: begin
          if (scl_fall && r.ph == 2'd0) begin
            n.drive = 1'b0;  // host owns the ack bit
            n.ph    = 2'd1;
          end else if (scl_rise && r.ph == 2'd1) begin
            if (r.sda_s2) begin
              n.st = S_IDLE;  // nack ends the read, wait for stop
            end else begin
              n.ph = 2'd2;
            end
          end else if (scl_fall && r.ph == 2'd2) begin
            n.st    = S_RBYTE;
            n.sh    = rd_byte;
            n.drive = !rd_byte[7];
            n.bitc  = 3'd0;
          end
        end
      endcase
    end
  end

  // state register, pins idle high at reset
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_p  <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_p  <= 1'b1;
      r.ctrl   <= rgbs_pkg::CTRL_RST_VAL;
      r.tman   <= rgbs_pkg::TMAN_RST_VAL;
    end else begin
      r <= n;
    end
  end

  assign mif.ctrl      = r.ctrl;
  assign mif.tman      = r.tman;
  assign sda_o         = 1'b0;
  assign sda_oe_o      = r.drive;
  assign standby_mon_o = mif.standby_mon;

  rgbs_integrator #(.BASE_CYC(BASE_CYC)) u_integ (
    .clk_i         (mclk_i),
    .rst_n_i       (rst_n),
    .chan_sample_i (chan_sample_i),
    .mif           (mif)
  );

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n);

  a_addr_miss: assert property (r.st == S_ADDR && scl_rise && r.bitc == 3'd7 && !start_c &&
    !stop_c && new_byte[7:1] != rgbs_pkg::DEV_ADDR |=> r.st == S_IDLE) // [R1]
    else $error("foreign address not ignored");
  a_ack_drive: assert property ((r.st == S_AACK || r.st == S_WACK) && r.ph == 2'd1
    |-> r.drive) // [R12]
    else $error("ack bit not driven low");
  a_ptr_load: assert property (r.st == S_WBYTE && scl_rise && r.bitc == 3'd7 && r.first &&
    !start_c && !stop_c |=> r.ptr == $past(new_byte) && !r.first) // [R2]
    else $error("pointer byte not loaded");
  a_ctrl_write: assert property (r.st == S_WBYTE && scl_rise && r.bitc == 3'd7 && !r.first &&
    r.ptr == rgbs_pkg::PTR_CTRL && !start_c && !stop_c
    |=> r.ctrl[7:6] == $past(new_byte[7:6]) && r.ptr == 8'd1) // [R13]
    else $error("control byte write lost");
  a_rd_advance: assert property (r.st == S_RBYTE && scl_rise && r.bitc == 3'd7 && !start_c &&
    !stop_c |=> r.st == S_RACK && r.ptr == $past(r.ptr) + 8'd1) // [R10]
    else $error("read pointer did not advance");
  a_rd_msb: assert property (r.st == S_RACK && r.ph == 2'd2 && scl_fall && !start_c && !stop_c
    |=> r.drive == !$past(rd_byte[7])) // [R10]
    else $error("next read byte msb not presented");
  c_ctrl_write: cover property (r.st == S_WACK && r.ptr == 8'd1);
  c_read_nack: cover property (r.st == S_RACK && r.ph == 2'd1 ##1 r.st == S_IDLE);
endmodule // rgbs_i2c_readout

/* File: bench/rgbs_i2c_host.sv */
// Purpose: behavioural I2C host that drives the sensor's bus port
// Assumes: pull-up on SDA, open drain on both sides, SCL idles high
// Notes:   all changes follow a falling mclk edge
`timescale 1ns/1ns
module rgbs_i2c_host (
  input  wire logic mclk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_o
);
  // bus released and SCL still between frames
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  // wait a number of falling edges
  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // start, also used as repeated start from SCL low
  task automatic start();
    sda_oe_o = 1'b0;
    tick(4);
    scl_o = 1'b1;
    tick(8);
    sda_oe_o = 1'b1;
    tick(8);
    scl_o = 1'b0;
    tick(5);
  endtask
  // stop releases SDA while SCL high
  task automatic stop();
    sda_oe_o = 1'b1;
    tick(5);
    scl_o = 1'b1;
    tick(8);
    sda_oe_o = 1'b0;
    tick(10);
  endtask
  // one bit out, the wire level sampled at the end of SCL high
  task automatic bit_io(input logic b, output logic r);
    sda_oe_o = ~b;
    tick(6);
    scl_o = 1'b1;
    tick(8);
    r = sda_i;
    scl_o = 1'b0;
    tick(5);
  endtask
  // eight bits msb first then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_in,
                      output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
endmodule // rgbs_i2c_host

/* File: bench/test_rgb_sensor_i2c_readout.sv */
// Purpose: self-checking bench of the colour sensor bus port
// Assumes: short base step so measurements finish in microseconds
// Notes:   one task per scenario, host model drives the bus
`timescale 1ns/1ns
module test_rgb_sensor_i2c_readout;
  localparam int BASE = 4;
  logic                     mclk_i  = 1'b0;
  logic                     rst_n_i = 1'b0;
  logic                     scl;
  logic                     host_oe;
  logic                     sda;
  logic                     dev_oe;
  logic                     dev_val;
  logic                     mon;
  rgbs_pkg::rgbs_chan_set_t samp    = '0;
  int                       err_count   = 0;
  int                       comparisons = 0;
  // clock and open drain wire with pull-up
  always #5 mclk_i = ~mclk_i;
  assign sda = !host_oe && (!dev_oe || dev_val);
  rgbs_i2c_readout #(.BASE_CYC(BASE)) u_rgbs_i2c_readout (
    .mclk_i        (mclk_i),
    .rst_n_i       (rst_n_i),
    .scl_i         (scl),
    .sda_i         (sda),
    .sda_o         (dev_val),
    .sda_oe_o      (dev_oe),
    .chan_sample_i (samp),
    .standby_mon_o (mon)
  );
  rgbs_i2c_host u_rgbs_i2c_host (
    .mclk_i   (mclk_i),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_oe_o (host_oe)
  );
  // verdict and end of run
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // compare and count
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // register write, stop only when asked so the next start is a repeat
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d, input logic do_stop);
    logic [7:0] rx;
    logic       ack;
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer({rgbs_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    u_rgbs_i2c_host.xfer(ptr, 1'b1, rx, ack);
    check(ack, 1'b0);
    u_rgbs_i2c_host.xfer(d, 1'b1, rx, ack);
    check(ack, 1'b0);
    if (do_stop) u_rgbs_i2c_host.stop();
  endtask
  // pointer to first result, repeated start, eight bytes, last one refused
  task automatic rd_all(input rgbs_pkg::rgbs_chan_set_t exp);
    logic [63:0] got;
    logic [7:0]  rx;
    logic        ack;
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer({rgbs_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    check(ack, 1'b0);
    u_rgbs_i2c_host.xfer(rgbs_pkg::PTR_RES_FIRST, 1'b1, rx, ack);
    check(ack, 1'b0);
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer({rgbs_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, ack);
    check(ack, 1'b0);
    for (int i = 0; i < 8; i++) begin
      u_rgbs_i2c_host.xfer(8'hff, (i == 7), rx, ack);
      got = {got[55:0], rx};
    end
    u_rgbs_i2c_host.stop();
    check(got, {exp[0], exp[1], exp[2], exp[3]});
  endtask
  // single byte read at a pointer, refused with a nack
  task automatic rd_one(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ack;
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer({rgbs_pkg::DEV_ADDR, 1'b0}, 1'b1, rx, ack);
    u_rgbs_i2c_host.xfer(ptr, 1'b1, rx, ack);
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer({rgbs_pkg::DEV_ADDR, 1'b1}, 1'b1, rx, ack);
    u_rgbs_i2c_host.xfer(8'hff, 1'b1, rx, ack);
    u_rgbs_i2c_host.stop();
    check(rx, exp);
  endtask
  // count cycles until the monitor rises, bounded
  task automatic wait_mon(output int n);
    n = 0;
    while (mon !== 1'b1) begin
      @(negedge mclk_i);
      n++;
      if (n > 5000) begin
        err_count++;
        finish_test();
      end
    end
  endtask
  // reset state and a foreign address
  task automatic t_reset();
    logic [7:0] rx;
    logic       ack;
    check(mon, 1'b0);
    check(dev_val, 1'b0);
    u_rgbs_i2c_host.start();
    u_rgbs_i2c_host.xfer(8'h56, 1'b1, rx, ack);
    check(ack, 1'b1);
    u_rgbs_i2c_host.stop();
  endtask
  // manual one-shot: 64 repeats, two base steps each, four channels
  task automatic t_manual();
    int n;
    samp = {16'h4d3c, 16'h2b1a, 16'h8877, 16'hf1e2};
    wr(rgbs_pkg::PTR_TMAN_HI, 8'h00, 1'b1);
    wr(rgbs_pkg::PTR_TMAN_LO, 8'h40, 1'b1);
    wr(rgbs_pkg::PTR_CTRL, 8'h84, 1'b0);
    wr(rgbs_pkg::PTR_CTRL, 8'h04, 1'b1);
    check(mon, 1'b0);
    wait_mon(n);
    check(n > 4 * 2 * 64 * BASE - 80, 1'b1);
    check(n < 4 * 2 * 64 * BASE + 10, 1'b1);
    rd_one(rgbs_pkg::PTR_CTRL, 8'h24);
    rd_one(rgbs_pkg::PTR_TMAN_LO, 8'h40);
    rd_all(samp);
    samp = {16'h1111, 16'h2222, 16'h3333, 16'h4444};
    rd_all({16'h4d3c, 16'h2b1a, 16'h8877, 16'hf1e2});
    samp = '0;
    rd_all({16'h4d3c, 16'h2b1a, 16'h8877, 16'hf1e2});
  endtask
  // fixed period: sixteen base steps a channel, repeats on its own
  task automatic t_fixed();
    samp = {16'h0102, 16'h0304, 16'h0506, 16'h0708};
    wr(rgbs_pkg::PTR_CTRL, 8'h89, 1'b0);
    wr(rgbs_pkg::PTR_CTRL, 8'h09, 1'b1);
    repeat (3 * 4 * 16 * BASE) @(negedge mclk_i);
    check(mon, 1'b0);
    rd_all(samp);
    samp = {16'hcafe, 16'hbeef, 16'h1234, 16'habcd};
    repeat (3 * 4 * 16 * BASE) @(negedge mclk_i);
    rd_all(samp);
    check(mon, 1'b0);
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge mclk_i);
    check(mon, 1'b1);
    rst_n_i = 1'b1;
    repeat (10) @(negedge mclk_i);
    t_reset();
    t_manual();
    t_fixed();
    finish_test();
  end
endmodule // test_rgb_sensor_i2c_readout
